// ### core/swled_ctrl.v
`timescale 1ns/1ps
`include "swled_map.vh"
module swled_ctrl #(
   parameter [19:0] EN_CYC = `SWLED_EN_TIME_US * `SWLED_CLK_MHZ,
   parameter [19:0] DIS_CYC = `SWLED_DIS_TIME_US * `SWLED_CLK_MHZ,
   parameter [25:0] TMO_CYC = `SWLED_TMO_TIME_US * `SWLED_CLK_MHZ,
   parameter [25:0] FMAX_CYC = `SWLED_FLASH_MAX_US * `SWLED_CLK_MHZ
)(
   input wire CLK,
   input wire RESET,
   input wire SINGLE_WIRE_PIN,
   input wire FLASH_TRIGGER_PIN_N,
   output reg DEVICE_ENABLED,
   output reg SLEEP,
   output reg OSC_RUN,
   output reg CHARGE_PUMP_ON,
   output reg SINK_ON,
   output reg RANGE_SELECT,
   output reg FLASH_TIMEOUT_ENABLE,
   output reg [2:0] SINK_CURRENT_CODE,
   output reg [8:0] SINK_CURRENT_MA,
   output reg [3:0] REGULATOR_A_CODE,
   output reg [11:0] REGULATOR_A_MV,
   output reg REGULATOR_A_ON,
   output reg [2:0] REGULATOR_B_CODE,
   output reg [10:0] REGULATOR_B_MV,
   output reg REGULATOR_B_ON
);
   // Receiver states
   localparam [3:0] S_OFF = 4'h0;
   localparam [3:0] S_IDLE = 4'h1;
   localparam [3:0] S_WLO = 4'h2;
   localparam [3:0] S_WHI = 4'h3;
   localparam [3:0] S_SLO = 4'h4;
   localparam [3:0] S_SHI = 4'h5;
   localparam [3:0] S_RX = 4'h6;
   localparam [3:0] S_PUSH = 4'h7;
   localparam [3:0] S_STBY = 4'h8;

   // Sink current in mA from code and range
   function [8:0] sink_ma;
      input [2:0] code;
      input range;
      begin
         if (code == 3'h0)
            sink_ma = 9'h000;
         else if (range)
            sink_ma = (code >= 3'h3) ? 9'h190 : 9'h0fa + {1'b0, code, 5'h00} + {2'h0, code, 4'h0} + {5'h00, code, 1'b0};
         else
            sink_ma = (code >= 3'h5) ? 9'h0fa : {1'b0, code, 5'h00} + {2'h0, code, 4'h0} + {5'h00, code, 1'b0};
      end
   endfunction

   // Regulator A in mV, zero when off
   function [11:0] regul_a_mv;
      input [3:0] code;
      begin
         if (code == 4'h0 || code > 4'h9)
            regul_a_mv = 12'h000;
         else
            regul_a_mv = 12'hd48 - {2'h0, code, 6'h00} - {3'h0, code, 5'h00} - {6'h00, code, 2'h0};
      end
   endfunction

   // Regulator B in mV, zero when off
   function [10:0] regul_b_mv;
      input [2:0] code;
      begin
         if (code == 3'h0 || code > 3'h4)
            regul_b_mv = 11'h000;
         else
            regul_b_mv = 11'h76c - {2'h0, code, 6'h00} - {3'h0, code, 5'h00} - {6'h00, code, 2'h0};
      end
   endfunction

   // Wire and trigger synchronisers
   reg w_meta;
   reg w_sync;
   reg w_prev;
   reg trig_meta;
   reg trig_sync;
   // Cycles since last wire edge
   reg [19:0] level_cnt;
   // Receiver state and timing
   reg [3:0] state;
   reg [15:0] lo_len;
   reg [15:0] period;
   reg [15:0] tmr;
   reg [3:0] nbits;
   reg [13:0] shreg;
   reg [12:0] frame;
   // Register contents
   reg [4:0] reg_flash;
   reg [6:0] reg_regul;
   // Flash timing
   reg [25:0] flash_tmr;
   reg tripped;
   // Apply slot divider
   reg [3:0] div_cnt;
   reg apply_tick;

   wire fall = w_prev & ~w_sync;
   wire rise = ~w_prev & w_sync;
   wire any_edge = fall | rise;
   wire long_high = w_sync & (level_cnt == EN_CYC);
   wire shutdown = ~w_sync & (level_cnt == DIS_CYC) & (state != S_OFF);
   wire too_long = (level_cnt[19:16] != 4'h0);
   wire [16:0] meas_sum = {1'b0, lo_len} + {1'b0, level_cnt[15:0]} + 17'h00001;
   wire [15:0] meas_period = meas_sum[16:1];
   wire [13:0] next_shreg = {shreg[12:0], w_sync};
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [12:0] fifo_out_data;
   wire wr_en = fifo_out_valid & apply_tick;
   wire wr_flash = wr_en & (fifo_out_data[12:8] == `SWLED_ADDR_FLASH);
   wire wr_regul = wr_en & (fifo_out_data[12:8] == `SWLED_ADDR_REGUL);
   wire [2:0] code = reg_flash[`SWLED_FLD_CODE_HI:`SWLED_FLD_CODE_LO];
   wire drive = (state != S_OFF) & (code != 3'h0) & ~tripped;
   wire trip = drive & ((reg_flash[`SWLED_FLD_TMO] & (flash_tmr == TMO_CYC - 26'h1)) |
                        (reg_flash[`SWLED_FLD_RANGE] & (flash_tmr == FMAX_CYC - 26'h1)));
   wire rearm = ~trig_sync | (wr_flash & (fifo_out_data[`SWLED_FLD_CODE_HI:`SWLED_FLD_CODE_LO] == 3'h0));

   // Two-stage synchronisers, wire is only ever sampled
   always @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         w_meta <= 1'b0;
         w_sync <= 1'b0;
         w_prev <= 1'b0;
         trig_meta <= 1'b1;
         trig_sync <= 1'b1;
      end
      else
      begin
         w_meta <= SINGLE_WIRE_PIN;
         w_sync <= w_meta;
         w_prev <= w_sync;
         trig_meta <= FLASH_TRIGGER_PIN_N;
         trig_sync <= trig_meta;
      end
   end

   // Level duration, saturating
   always @(posedge CLK or posedge RESET)
   begin
      if (RESET)
         level_cnt <= 20'h00000;
      else if (any_edge)
         level_cnt <= 20'h00000;
      else if (level_cnt != 20'hfffff)
         level_cnt <= level_cnt + 20'h00001;
   end

   // Receiver sequence, sampling at full clock rate
   always @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         state <= S_OFF;
         lo_len <= 16'h0000;
         period <= 16'h0000;
         tmr <= 16'h0000;
         nbits <= 4'h0;
         shreg <= 14'h0000;
         frame <= 13'h0000;
      end
      else if (shutdown)
         state <= S_OFF;
      else
      begin
         case (state)
            // Shut down until a long high
            S_OFF:
               if (long_high)
                  state <= S_IDLE;
            // Sleep or standby, watch for wake
            S_IDLE:
               if (fall)
                  state <= S_WLO;
            // Oscillator wake, low half
            S_WLO:
               if (rise)
                  state <= S_WHI;
            // Oscillator wake, high half
            S_WHI:
               if (fall)
                  state <= S_SLO;
               else if (too_long)
                  state <= S_IDLE;
            // Rate sample, low half measured
            S_SLO:
               if (rise)
               begin
                  lo_len <= level_cnt[15:0] + 16'h0001;
                  state <= S_SHI;
               end
               else if (too_long)
                  state <= S_IDLE;
            // Rate sample, high half measured, fall opens start bit
            S_SHI:
               if (fall)
               begin
                  period <= meas_period;
                  tmr <= 16'h0000;
                  nbits <= 4'h0;
                  if (meas_period < `SWLED_MIN_OVERSAMPLE)
                     state <= S_IDLE;
                  else
                     state <= S_RX;
               end
               else if (too_long)
                  state <= S_IDLE;
            // Start, address and data bits at mid period
            S_RX:
            begin
               if (any_edge || tmr == period - 16'h0001)
                  tmr <= 16'h0000;
               else
                  tmr <= tmr + 16'h0001;
               if (!any_edge && tmr == {1'b0, period[15:1]})
               begin
                  shreg <= next_shreg;
                  nbits <= nbits + 4'h1;
                  if (nbits == `SWLED_FRAME_BITS)
                  begin
                     frame <= next_shreg[12:0];
                     if (next_shreg[13])
                        state <= S_IDLE;
                     else
                        state <= S_PUSH;
                  end
               end
            end
            // Hand frame to queue, hold while it is full
            S_PUSH:
               if (fifo_in_ready)
               begin
                  tmr <= 16'h0000;
                  nbits <= 4'h0;
                  // Still inside the last bit, decide one period on
                  state <= S_STBY;
               end
            // Count high periods back to standby
            S_STBY:
               if (fall)
                  state <= S_WLO;
               else if (tmr == period - 16'h0001)
               begin
                  tmr <= 16'h0000;
                  nbits <= nbits + 4'h1;
                  // Low one period after a low last bit: chained wake
                  if (!w_sync)
                     state <= S_WLO;
                  else if (nbits == `SWLED_STBY_BITS - 4'h1)
                     state <= S_IDLE;
               end
               else
                  tmr <= tmr + 16'h0001;
            default:
               state <= S_OFF;
         endcase
      end
   end

   // Write queue between receiver and registers
   swled_fifo #(
      .WIDTH(13),
      .DEPTH(4),
      .AW(2)
   ) u_fifo (
      .clk(CLK),
      .reset(RESET),
      .clr(shutdown),
      .in_data(frame),
      .in_valid(state == S_PUSH),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out_data),
      .out_valid(fifo_out_valid),
      .out_ready(apply_tick)
   );

   // Divider giving register apply slots
   always @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         div_cnt <= 4'h0;
         apply_tick <= 1'b0;
      end
      else
      begin
         apply_tick <= (div_cnt == `SWLED_APPLY_DIV);
         div_cnt <= div_cnt + 4'h1;
      end
   end

   // Control registers, shutdown restores defaults
   always @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         reg_flash <= `SWLED_RST_FLASH;
         reg_regul <= `SWLED_RST_REGUL;
      end
      else if (shutdown)
      begin
         reg_flash <= `SWLED_RST_FLASH;
         reg_regul <= `SWLED_RST_REGUL;
      end
      else
      begin
         // Unused upper bits dropped; other addresses ignored
         if (wr_flash)
            reg_flash <= fifo_out_data[4:0];
         if (wr_regul)
            reg_regul <= fifo_out_data[6:0];
      end
   end

   // Flash on-time and safety trip
   always @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         flash_tmr <= 26'h0000000;
         tripped <= 1'b0;
      end
      else if (shutdown)
      begin
         flash_tmr <= 26'h0000000;
         tripped <= 1'b0;
      end
      else
      begin
         if (drive)
            flash_tmr <= flash_tmr + 26'h0000001;
         else
            flash_tmr <= 26'h0000000;
         // Trip wins over a rearm in the same cycle
         if (trip)
            tripped <= 1'b1;
         else if (rearm)
            tripped <= 1'b0;
      end
   end

   // Registered outputs
   always @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         DEVICE_ENABLED <= 1'b0;
         SLEEP <= 1'b0;
         OSC_RUN <= 1'b0;
         CHARGE_PUMP_ON <= 1'b0;
         SINK_ON <= 1'b0;
         RANGE_SELECT <= 1'b0;
         FLASH_TIMEOUT_ENABLE <= 1'b1;
         SINK_CURRENT_CODE <= 3'h0;
         SINK_CURRENT_MA <= 9'h000;
         REGULATOR_A_CODE <= 4'h0;
         REGULATOR_A_MV <= 12'h000;
         REGULATOR_A_ON <= 1'b0;
         REGULATOR_B_CODE <= 3'h0;
         REGULATOR_B_MV <= 11'h000;
         REGULATOR_B_ON <= 1'b0;
      end
      else
      begin
         DEVICE_ENABLED <= (state != S_OFF);
         // Sleep when no sink and no frame in flight
         SLEEP <= (state == S_IDLE) & ~drive;
         OSC_RUN <= (state != S_OFF) & ((state != S_IDLE) | drive);
         CHARGE_PUMP_ON <= drive;
         SINK_ON <= drive;
         RANGE_SELECT <= reg_flash[`SWLED_FLD_RANGE];
         FLASH_TIMEOUT_ENABLE <= reg_flash[`SWLED_FLD_TMO];
         SINK_CURRENT_CODE <= code;
         SINK_CURRENT_MA <= drive ? sink_ma(code, reg_flash[`SWLED_FLD_RANGE]) : 9'h000;
         REGULATOR_A_CODE <= reg_regul[`SWLED_FLD_A_HI:`SWLED_FLD_A_LO];
         REGULATOR_A_MV <= regul_a_mv(reg_regul[`SWLED_FLD_A_HI:`SWLED_FLD_A_LO]);
         REGULATOR_A_ON <= (regul_a_mv(reg_regul[`SWLED_FLD_A_HI:`SWLED_FLD_A_LO]) != 12'h000);
         REGULATOR_B_CODE <= reg_regul[`SWLED_FLD_B_HI:`SWLED_FLD_B_LO];
         REGULATOR_B_MV <= regul_b_mv(reg_regul[`SWLED_FLD_B_HI:`SWLED_FLD_B_LO]);
         REGULATOR_B_ON <= (regul_b_mv(reg_regul[`SWLED_FLD_B_HI:`SWLED_FLD_B_LO]) != 11'h000);
      end
   end
endmodule // swled_ctrl

// ### core/swled_map.vh
// Behaviour
// - Range bit one: flash range, 500ms cap
// - Range bit zero: spotlight range, continuous drive
// - Regulator B code selects 1.8V..1.5V or off
// - Regulator A code selects 3.3V..2.5V or off
// - Wire is write-only, 32 addresses, never driven
// - High over 1ms enables device into sleep
// - Sink disabled: sleep, pump and oscillator off
// - Low over 10ms shuts down until high
// - Shutdown restores register defaults, timeout enable one
// - Write opens with low/high oscillator wake
// - Low/high rate sample fixes bit period
// - Oversample at least twenty times bit rate
// - One low start bit follows rate sample
// - Five address bits, MSB first
// - Eight data bits, MSB first, written
// - Five high periods return to standby
// - Chained write repeats wake after data
// - Timeout enable stops flash after 1s
// - Current code maps to milliamps per range
`ifndef SWLED_MAP_VH
`define SWLED_MAP_VH
// Clock rate in MHz
`define SWLED_CLK_MHZ 50
// Register addresses on the wire
`define SWLED_ADDR_FLASH 5'h02
`define SWLED_ADDR_REGUL 5'h03
// Flash register field positions
`define SWLED_FLD_RANGE 0
`define SWLED_FLD_CODE_LO 1
`define SWLED_FLD_CODE_HI 3
`define SWLED_FLD_TMO 4
// Regulator register field positions
`define SWLED_FLD_A_LO 0
`define SWLED_FLD_A_HI 3
`define SWLED_FLD_B_LO 4
`define SWLED_FLD_B_HI 6
// Reset values of the used bits
`define SWLED_RST_FLASH 5'h10
`define SWLED_RST_REGUL 7'h00
// Times in microseconds
`define SWLED_EN_TIME_US 1000
`define SWLED_DIS_TIME_US 10000
`define SWLED_TMO_TIME_US 1000000
`define SWLED_FLASH_MAX_US 500000
// Protocol counts
`define SWLED_MIN_OVERSAMPLE 16'h0014
`define SWLED_STBY_BITS 4'h5
`define SWLED_FRAME_BITS 4'hd
// Register apply divider, count at which each write slot fires, slots 16 cycles apart
`define SWLED_APPLY_DIV 4'hf
`endif

// ### core/swled_fifo.v
`timescale 1ns/1ps
module swled_fifo #(
   parameter WIDTH = 13,
   parameter DEPTH = 4,
   parameter AW = 2
)(
   input wire clk,
   input wire reset,
   input wire clr,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output reg [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   // Storage words
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   // Pointers and fill level
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;

   // Room while fewer than DEPTH words held
   assign in_ready = (count < DEPTH);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Output word follows read pointer
   always @*
   begin
      out_data = mem[rd_ptr];
   end

   // Storage write
   always @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Pointer and level update
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end
      else if (clr)
      begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
         if (push & ~pop)
            count <= count + 1'b1;
         else if (pop & ~push)
            count <= count - 1'b1;
      end
   end
endmodule // swled_fifo

// ### test/swled_host.sv
`timescale 1ns/1ps
module swled_host (
   input wire clk,
   output reg wire_o
);
   // Push-pull host output, never released
   task lvl(input b, input integer n);
      begin
         wire_o <= b;
         repeat (n) @(posedge clk);
      end
   endtask

   // Wake, rate sample, start, then bits MSB first
   task frame(input [4:0] a, input [7:0] d, input integer t, input chain);
      integer i;
      reg [12:0] s;
      begin
         s = {a, d};
         lvl(1'b0, t);
         lvl(1'b1, t);
         lvl(1'b0, t);
         lvl(1'b1, t);
         lvl(1'b0, t);
         for (i = 12; i >= 0; i = i - 1)
            lvl(s[i], t);
         if (!chain)
            lvl(1'b1, 5 * t);
      end
   endtask

   // Wire starts low, device shut down
   initial wire_o = 1'b0;
endmodule // swled_host

// ### test/swled_chk.sv
`timescale 1ns/1ps
module swled_chk #(
   parameter [19:0] EN_CYC = 20'h000c8,
   parameter [19:0] DIS_CYC = 20'h007d0,
   parameter [25:0] TMO_CYC = 26'h0000bb8,
   parameter [25:0] FMAX_CYC = 26'h00005dc
)(
   input wire CLK,
   input wire RESET,
   input wire SINGLE_WIRE_PIN,
   input wire DEVICE_ENABLED,
   input wire SLEEP,
   input wire CHARGE_PUMP_ON,
   input wire SINK_ON,
   input wire RANGE_SELECT,
   input wire FLASH_TIMEOUT_ENABLE,
   input wire [2:0] SINK_CURRENT_CODE,
   input wire [8:0] SINK_CURRENT_MA,
   input wire [3:0] REGULATOR_A_CODE,
   input wire [11:0] REGULATOR_A_MV,
   input wire REGULATOR_A_ON,
   input wire [2:0] REGULATOR_B_CODE,
   input wire [10:0] REGULATOR_B_MV,
   input wire REGULATOR_B_ON
);
   reg [25:0] hi_cnt; // Wire high run
   reg [25:0] lo_cnt; // Wire low run
   reg [25:0] drv_cnt; // Sink drive run
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RESET);

   // Run lengths of wire levels and sink drive
   always @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         hi_cnt <= 26'h0;
         lo_cnt <= 26'h0;
         drv_cnt <= 26'h0;
      end
      else
      begin
         hi_cnt <= SINGLE_WIRE_PIN ? hi_cnt + 26'h1 : 26'h0;
         lo_cnt <= SINGLE_WIRE_PIN ? 26'h0 : lo_cnt + 26'h1;
         drv_cnt <= SINK_ON ? drv_cnt + 26'h1 : 26'h0;
      end
   end

   // Wire low well past the disable time
   sequence s_long_low;
      lo_cnt == DIS_CYC + 26'h8;
   endsequence
   property p_en_late;
      $rose(DEVICE_ENABLED) |-> hi_cnt > EN_CYC;
   endproperty
   property p_dis_late;
      $fell(DEVICE_ENABLED) |-> lo_cnt > DIS_CYC;
   endproperty
   property p_dis_by;
      s_long_low |-> !DEVICE_ENABLED;
   endproperty
   property p_defaults;
      $fell(DEVICE_ENABLED) |=> FLASH_TIMEOUT_ENABLE && !RANGE_SELECT && SINK_CURRENT_CODE == 3'h0
         && REGULATOR_A_CODE == 4'h0 && REGULATOR_B_CODE == 3'h0;
   endproperty
   property p_ma;
      SINK_CURRENT_MA == (!SINK_ON ? 0 : RANGE_SELECT ? (SINK_CURRENT_CODE < 3 ? 250 + 50 * SINK_CURRENT_CODE : 400)
         : (SINK_CURRENT_CODE > 4 ? 250 : 50 * SINK_CURRENT_CODE));
   endproperty
   property p_rega;
      (REGULATOR_A_CODE >= 1 && REGULATOR_A_CODE <= 9) ? (REGULATOR_A_ON && REGULATOR_A_MV == 3400 - 100 * REGULATOR_A_CODE)
         : (!REGULATOR_A_ON && REGULATOR_A_MV == 0);
   endproperty
   property p_regb;
      (REGULATOR_B_CODE >= 1 && REGULATOR_B_CODE <= 4) ? (REGULATOR_B_ON && REGULATOR_B_MV == 1900 - 100 * REGULATOR_B_CODE)
         : (!REGULATOR_B_ON && REGULATOR_B_MV == 0);
   endproperty
   property p_pump;
      CHARGE_PUMP_ON == SINK_ON && !(SLEEP && SINK_ON);
   endproperty
   property p_fmax;
      SINK_ON && RANGE_SELECT |-> drv_cnt <= FMAX_CYC + 26'h4;
   endproperty
   property p_tmo;
      SINK_ON && FLASH_TIMEOUT_ENABLE |-> drv_cnt <= TMO_CYC + 26'h4;
   endproperty
   a_en_late: assert property (p_en_late) else $error("enabled too early");
   a_dis_late: assert property (p_dis_late) else $error("shut down too early");
   a_dis_by: assert property (p_dis_by) else $error("no shutdown on long low");
   a_defaults: assert property (p_defaults) else $error("defaults not restored");
   a_ma: assert property (p_ma) else $error("sink current wrong");
   a_rega: assert property (p_rega) else $error("regulator A wrong");
   a_regb: assert property (p_regb) else $error("regulator B wrong");
   a_pump: assert property (p_pump) else $error("pump or sleep wrong");
   a_fmax: assert property (p_fmax) else $error("flash range drive too long");
   a_tmo: assert property (p_tmo) else $error("timeout missed");
endmodule // swled_chk

bind swled_ctrl swled_chk #(.EN_CYC(EN_CYC), .DIS_CYC(DIS_CYC), .TMO_CYC(TMO_CYC), .FMAX_CYC(FMAX_CYC)) u_chk (.*);

// ### test/single_wire_led_pmic_control_test.sv
`timescale 1ns/1ps
`define CHK(g, e) check(g, e)
module single_wire_led_pmic_control_test;
   reg clk, reset, trig_n;
   wire pin, en, slp, osc, pump, sink, rng, tmo, aon, bon;
   wire [2:0] fcode, bcode;
   wire [3:0] acode;
   wire [8:0] ma;
   wire [10:0] bmv;
   wire [11:0] amv;
   integer err_count, num_checks, fl, rg, i;
   swled_host host (.clk(clk), .wire_o(pin));
   swled_ctrl #(.EN_CYC(20'h000c8), .DIS_CYC(20'h007d0), .TMO_CYC(26'h0000bb8), .FMAX_CYC(26'h00005dc)) dut (
      .CLK(clk), .RESET(reset), .SINGLE_WIRE_PIN(pin), .FLASH_TRIGGER_PIN_N(trig_n),
      .DEVICE_ENABLED(en), .SLEEP(slp), .OSC_RUN(osc), .CHARGE_PUMP_ON(pump), .SINK_ON(sink),
      .RANGE_SELECT(rng), .FLASH_TIMEOUT_ENABLE(tmo), .SINK_CURRENT_CODE(fcode), .SINK_CURRENT_MA(ma),
      .REGULATOR_A_CODE(acode), .REGULATOR_A_MV(amv), .REGULATOR_A_ON(aon),
      .REGULATOR_B_CODE(bcode), .REGULATOR_B_MV(bmv), .REGULATOR_B_ON(bon));

   // Model of expected current and voltages
   function integer ma_exp(input integer f);
      integer c;
      begin
         c = (f >> 1) & 7;
         ma_exp = (c == 0) ? 0 : (f & 1) ? ((c < 3) ? 250 + 50 * c : 400) : ((c > 4) ? 250 : 50 * c);
      end
   endfunction
   function integer amv_exp(input integer a);
      amv_exp = (a >= 1 && a <= 9) ? 3400 - 100 * a : 0;
   endfunction
   function integer bmv_exp(input integer b);
      bmv_exp = (b >= 1 && b <= 4) ? 1900 - 100 * b : 0;
   endfunction
   // Random bit period within device limits
   function integer tt;
      tt = 20 + $urandom % 12;
   endfunction

   // Compare and count
   task check(input logic [31:0] g, input logic [31:0] e);
      begin
         num_checks = num_checks + 1;
         if (g !== e)
         begin
            err_count = err_count + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   task cmp_all;
      begin
         `CHK(rng, fl[0]);
         `CHK(tmo, fl[4]);
         `CHK(fcode, fl[3:1]);
         `CHK(amv, amv_exp(rg & 15));
         `CHK(aon, amv_exp(rg & 15) != 0);
         `CHK(bmv, bmv_exp((rg >> 4) & 7));
         `CHK(bon, bmv_exp((rg >> 4) & 7) != 0);
      end
   endtask
   // Flash write after clearing the code, chained
   task wrf(input [7:0] d);
      integer t;
      begin
         t = tt();
         host.frame(5'h02, 8'h00, t, 1'b1);
         host.frame(5'h02, d, t, 1'b0);
         fl = d;
         // Let standby finish before sleep is judged
         repeat (40) @(posedge clk);
      end
   endtask
   task done(input string s);
      $display("test %s done checks=%0d errors=%0d", s, num_checks, err_count);
   endtask
   task summarize;
      begin
         $display("checks=%0d errors=%0d", num_checks, err_count);
         if (err_count == 0 && num_checks > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask

   // Clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Watchdog
   initial
   begin
      repeat (100000) @(posedge clk);
      err_count = err_count + 1;
      summarize;
   end

   // Main sequence
   initial
   begin
      err_count = 0;
      num_checks = 0;
      fl = 8'h10;
      rg = 0;
      reset = 1'b1;
      trig_n = 1'b1;
      void'($urandom(32'h1f));
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      cmp_all;
      `CHK(en, 0);
      host.lvl(1'b1, 240);
      `CHK(en, 1);
      `CHK(slp, 1);
      done("enable");
      for (i = 0; i < 16; i = i + 1)
      begin
         rg = ((i & 7) << 4) | i;
         host.frame(5'h03, rg[7:0], tt(), 1'b0);
         cmp_all;
      end
      done("regulators");
      for (i = 0; i < 16; i = i + 1)
      begin
         wrf(i[7:0]);
         cmp_all;
         `CHK(ma, ma_exp(fl));
         `CHK(sink, (fl & 14) != 0);
         `CHK(pump, (fl & 14) != 0);
         `CHK(osc, (fl & 14) != 0);
         `CHK(slp, (fl & 14) == 0);
      end
      done("flash codes");
      for (i = 0; i < 3; i = i + 1)
      begin
         host.frame(5'h04 + ($urandom % 28), 8'h3f, tt(), 1'b0);
         cmp_all;
      end
      done("unmapped");
      wrf(8'h12);
      `CHK(sink, 1);
      repeat (3100) @(posedge clk);
      `CHK(sink, 0);
      `CHK(ma, 0);
      trig_n <= 1'b0;
      repeat (4) @(posedge clk);
      trig_n <= 1'b1;
      repeat (6) @(posedge clk);
      `CHK(sink, 1);
      done("timeout");
      wrf(8'h03);
      `CHK(ma, 300);
      repeat (1600) @(posedge clk);
      `CHK(sink, 0);
      wrf(8'h02);
      repeat (3500) @(posedge clk);
      `CHK(ma, ma_exp(fl));
      done("ranges");
      host.lvl(1'b0, 2100);
      `CHK(en, 0);
      fl = 8'h10;
      rg = 0;
      cmp_all;
      host.frame(5'h03, 8'h21, tt(), 1'b0);
      cmp_all;
      host.lvl(1'b1, 240);
      `CHK(en, 1);
      host.frame(5'h03, 8'h21, tt(), 1'b0);
      rg = 8'h21;
      cmp_all;
      done("shutdown");
      summarize;
   end
endmodule // single_wire_led_pmic_control_test
